/* src/tc_status_pkg.sv */
package tc_status_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses within the channel)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_COMPARE_C = 8'h1c;
  localparam logic [7:0] OFS_EVENT_FLAGS = 8'h20;
  localparam logic [7:0] OFS_IRQ_ENABLE_SET = 8'h24;
  localparam logic [7:0] OFS_IRQ_ENABLE_CLEAR = 8'h28;
  localparam logic [7:0] OFS_IRQ_MASK_VIEW = 8'h2c;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int NUM_EVENTS = 8;
  localparam int BIT_OVERFLOW = 0;
  localparam int BIT_LOAD_OVERRUN = 1;
  localparam int BIT_COMPARE_A = 2;
  localparam int BIT_COMPARE_B = 3;
  localparam int BIT_COMPARE_C = 4;
  localparam int BIT_LOAD_A = 5;
  localparam int BIT_LOAD_B = 6;
  localparam int BIT_EXT_TRIGGER = 7;
  localparam int BIT_CLOCK_STATE = 16;
  localparam int BIT_LINE_A_MIRROR = 17;
  localparam int BIT_LINE_B_MIRROR = 18;
  localparam int COMPARE_MSB = 15;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_COMPARE_C = 16'h0000;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // raw event pulses from the counter core, one cycle each
  typedef struct packed {
    logic ext_trigger;
    logic load_b;
    logic load_a;
    logic compare_c;
    logic compare_b;
    logic compare_a;
    logic overflow;
  } core_events_t;

endpackage : tc_status_pkg

/* src/tc_event_flags.sv */
`timescale 1ns/100ps
// sticky event flags, cleared as a group by a status read; set wins over clear
module tc_event_flags (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic [7:0] set_vec,
  input wire logic clear_all,
  // state
  output logic [7:0] flags
);

  logic [7:0] flags_reg;
  logic [7:0] flags_next;

  genvar i;
  generate
    for (i = 0; i < tc_status_pkg::NUM_EVENTS; i++) begin : g_flag
      // an event in the read cycle survives into the next read
      assign flags_next[i] = set_vec[i] | (flags_reg[i] & ~clear_all);
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= tc_status_pkg::RST_FLAGS;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign flags = flags_reg;

endmodule : tc_event_flags

/* src/timer_channel_status_irq.sv */
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
// What this block does
// - compare C register, 16 bits, upper zero
// - overflow flag; status read clears all flags not set in the same cycle
// - capture mode: second unread load sets overrun
// - pattern mode: A match sets compare A flag
// - pattern mode: B match sets compare B flag
// - C match sets compare C flag always
// - capture mode: A load sets load A flag
// - capture mode: B load sets load B flag
// - external trigger sets its flag always
// - bit 16 shows counter clock enabled
// - bit 17 mirrors line A level
// - bit 18 mirrors line B level
// - enable-set write ones set mask bits
// - enable-clear write ones clear mask bits
// - mask view reads current mask
// - mode bit: zero capture, one pattern
module timer_channel_status_irq (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // counter core
  input wire logic pattern_mode,
  input wire logic clock_enabled,
  input wire tc_status_pkg::core_events_t core_ev,
  input wire logic capture_a_read,
  input wire logic capture_b_read,
  // channel lines
  input wire logic timer_line_a_in,
  input wire logic timer_line_b_in,
  input wire logic timer_line_a_drive,
  input wire logic timer_line_b_drive,
  // outputs
  output logic [15:0] compare_c_value,
  output logic irq
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  wire logic wr_c = reg_wr & hit(reg_addr, tc_status_pkg::OFS_COMPARE_C);
  wire logic wr_set = reg_wr & hit(reg_addr, tc_status_pkg::OFS_IRQ_ENABLE_SET);
  wire logic wr_clr = reg_wr & hit(reg_addr, tc_status_pkg::OFS_IRQ_ENABLE_CLEAR);
  wire logic rd_status = reg_rd & hit(reg_addr, tc_status_pkg::OFS_EVENT_FLAGS);

  // ----------------------------------------------------------------
  // compare C
  // ----------------------------------------------------------------
  logic [15:0] compare_c_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      compare_c_reg <= tc_status_pkg::RST_COMPARE_C;
    end else if (wr_c) begin
      compare_c_reg <= reg_wdata[tc_status_pkg::COMPARE_MSB:0];
    end
  end
  assign compare_c_value = compare_c_reg;

  // ----------------------------------------------------------------
  // load overrun tracking: a capture register loaded but not yet read
  // ----------------------------------------------------------------
  logic pend_a_reg;
  logic pend_b_reg;
  wire logic capture = ~pattern_mode;
  wire logic ld_a = capture & core_ev.load_a;
  wire logic ld_b = capture & core_ev.load_b;
  // a read in the same cycle as a load leaves the new value unread
  wire logic pend_a_next = ld_a | (pend_a_reg & ~capture_a_read & capture);
  wire logic pend_b_next = ld_b | (pend_b_reg & ~capture_b_read & capture);
  wire logic overrun = (ld_a & pend_a_reg & ~capture_a_read)
                     | (ld_b & pend_b_reg & ~capture_b_read);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_a_reg <= 1'b0;
      pend_b_reg <= 1'b0;
    end else begin
      pend_a_reg <= pend_a_next;
      pend_b_reg <= pend_b_next;
    end
  end

  // ----------------------------------------------------------------
  // event flags
  // ----------------------------------------------------------------
  logic [7:0] set_vec;
  logic [7:0] flags;
  assign set_vec[tc_status_pkg::BIT_OVERFLOW] = core_ev.overflow;
  assign set_vec[tc_status_pkg::BIT_LOAD_OVERRUN] = overrun;
  assign set_vec[tc_status_pkg::BIT_COMPARE_A] = pattern_mode & core_ev.compare_a;
  assign set_vec[tc_status_pkg::BIT_COMPARE_B] = pattern_mode & core_ev.compare_b;
  assign set_vec[tc_status_pkg::BIT_COMPARE_C] = core_ev.compare_c;
  assign set_vec[tc_status_pkg::BIT_LOAD_A] = ld_a;
  assign set_vec[tc_status_pkg::BIT_LOAD_B] = ld_b;
  assign set_vec[tc_status_pkg::BIT_EXT_TRIGGER] = core_ev.ext_trigger;

  tc_event_flags u_flags (
    .clk(clk),
    .rst_n(rst_n),
    .set_vec(set_vec),
    .clear_all(rd_status),
    .flags(flags)
  );

  // ----------------------------------------------------------------
  // interrupt mask
  // ----------------------------------------------------------------
  logic [7:0] mask_reg;
  logic [7:0] mask_next;
  // set and clear in one cycle cannot happen: strobes address one register
  assign mask_next = wr_set ? (mask_reg | reg_wdata[7:0])
                   : wr_clr ? (mask_reg & ~reg_wdata[7:0])
                   : mask_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_reg <= tc_status_pkg::RST_MASK;
    end else begin
      mask_reg <= mask_next;
    end
  end

  // ----------------------------------------------------------------
  // interrupt, registered from next-state so it tracks flags in step
  // ----------------------------------------------------------------
  logic [7:0] flags_next_view;
  assign flags_next_view = set_vec | (flags & {8{~rd_status}});
  logic irq_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(flags_next_view & mask_next);
    end
  end
  assign irq = irq_reg;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  wire logic line_a = pattern_mode ? timer_line_a_drive : timer_line_a_in;
  wire logic line_b = pattern_mode ? timer_line_b_drive : timer_line_b_in;
  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[7:0] = flags;
    status_word[tc_status_pkg::BIT_CLOCK_STATE] = clock_enabled;
    status_word[tc_status_pkg::BIT_LINE_A_MIRROR] = line_a;
    status_word[tc_status_pkg::BIT_LINE_B_MIRROR] = line_b;
  end

  logic [31:0] rdata_next;
  always_comb begin
    rdata_next = 32'h0000_0000;
    case (reg_addr)
      tc_status_pkg::OFS_COMPARE_C: rdata_next = {16'h0000, compare_c_reg};
      tc_status_pkg::OFS_EVENT_FLAGS: rdata_next = status_word;
      tc_status_pkg::OFS_IRQ_MASK_VIEW: rdata_next = {24'h000000, mask_reg};
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  logic [31:0] rdata_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= tc_status_pkg::RST_RDATA;
    end else if (reg_rd) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end
  assign reg_rdata = rdata_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_C_WRITE: assert property (wr_c |=> compare_c_value == $past(reg_wdata[15:0]))
    else $error("compare C did not take write");
  AST_READ_CLEARS: assert property (rd_status && set_vec == 8'h00 |=> flags == 8'h00)
    else $error("status read did not clear flags");
  AST_OVF_SET: assert property (core_ev.overflow |=> flags[0])
    else $error("overflow flag not set");
  AST_OVERRUN: assert property (ld_a && pend_a_reg && !capture_a_read |=> flags[1])
    else $error("load overrun not flagged");
  AST_CMPA_CAPT: assert property (!pattern_mode && !flags[2] && !rd_status |=> !flags[2]
                                   || $past(pattern_mode) != pattern_mode)
    else $error("compare A flag set in capture mode");
  AST_CMPB: assert property (pattern_mode && core_ev.compare_b |=> flags[3])
    else $error("compare B flag not set");
  AST_CMPC: assert property (core_ev.compare_c |=> flags[4])
    else $error("compare C flag not set");
  AST_LDA: assert property (!pattern_mode && core_ev.load_a |=> flags[5])
    else $error("load A flag not set");
  AST_LDB: assert property (!pattern_mode && core_ev.load_b |=> flags[6])
    else $error("load B flag not set");
  AST_TRIG: assert property (core_ev.ext_trigger |=> flags[7])
    else $error("trigger flag not set");
  AST_STATUS_RD: assert property (rd_status |=>
      reg_rdata[16] == $past(clock_enabled) && reg_rdata[17] == $past(line_a))
    else $error("status read bits wrong");
  AST_MASK_SET: assert property (wr_set |=> (mask_reg & $past(reg_wdata[7:0]))
                                  == $past(reg_wdata[7:0]))
    else $error("enable set failed");
  AST_MASK_CLR: assert property (wr_clr |=> (mask_reg & $past(reg_wdata[7:0])) == 8'h00)
    else $error("enable clear failed");
  AST_IRQ: assert property (irq == |(flags & mask_reg))
    else $error("interrupt does not match flags and mask");

  // ----------------------------------------------------------------
  // checks: mode gating, compare A sets in pattern mode, a flag that cannot set stays clear
  // ----------------------------------------------------------------
  AST_CMPA_PAT: assert property (pattern_mode && core_ev.compare_a |=> flags[2])
    else $error("compare A flag not set");
  AST_CMPB_CAPT: assert property (!pattern_mode && !flags[3] |=> !flags[3])
    else $error("compare B flag set in capture mode");
  AST_OVR_PAT: assert property (pattern_mode && !flags[1] |=> !flags[1])
    else $error("load overrun flag set in pattern mode");
  AST_LDA_PAT: assert property (pattern_mode && !flags[5] |=> !flags[5])
    else $error("load A flag set in pattern mode");
  AST_LDB_PAT: assert property (pattern_mode && !flags[6] |=> !flags[6])
    else $error("load B flag set in pattern mode");
  AST_PEND_PAT: assert property (pattern_mode |=> !pend_a_reg && !pend_b_reg)
    else $error("pending load kept in pattern mode");

  // ----------------------------------------------------------------
  // checks: load overrun tracking
  // ----------------------------------------------------------------
  AST_PEND_A_SET: assert property (ld_a |=> pend_a_reg)
    else $error("load A not marked pending");
  AST_PEND_A_READ: assert property (capture_a_read && !ld_a |=> !pend_a_reg)
    else $error("read of capture A left it pending");
  AST_OVERRUN_B: assert property (ld_b && pend_b_reg && !capture_b_read |=> flags[1])
    else $error("load B overrun not flagged");
  // a load after a read of that register is no overrun
  AST_NO_OVERRUN: assert property (!flags[1] && !(ld_a && pend_a_reg)
      && !(ld_b && pend_b_reg) |=> !flags[1])
    else $error("load overrun flagged without a second load");

  // ----------------------------------------------------------------
  // checks: sticky flags, the status word and the interrupt
  // ----------------------------------------------------------------
  AST_FLAGS_HOLD: assert property (!rd_status && set_vec == 8'h00
      |=> flags == $past(flags))
    else $error("flag changed with no event and no read");
  AST_SET_ON_READ: assert property (rd_status |=> flags == $past(set_vec))
    else $error("status read lost a same-cycle event");
  AST_STATUS_LOW: assert property (rd_status |=> reg_rdata[7:0] == $past(flags))
    else $error("status read flag byte wrong");
  AST_STATUS_PAD: assert property (rd_status
      |=> reg_rdata[31:19] == 13'h0000 && reg_rdata[15:8] == 8'h00)
    else $error("status read unused bits not zero");
  AST_CLOCK_STATE: assert property (rd_status |=> reg_rdata[16] == $past(clock_enabled))
    else $error("clock state bit wrong");
  AST_LINE_A_CAPT: assert property (rd_status && !pattern_mode
      |=> reg_rdata[17] == $past(timer_line_a_in))
    else $error("line A mirror wrong in capture mode");
  AST_LINE_A_PAT: assert property (rd_status && pattern_mode
      |=> reg_rdata[17] == $past(timer_line_a_drive))
    else $error("line A mirror wrong in pattern mode");
  AST_LINE_B_CAPT: assert property (rd_status && !pattern_mode
      |=> reg_rdata[18] == $past(timer_line_b_in))
    else $error("line B mirror wrong in capture mode");
  AST_LINE_B_PAT: assert property (rd_status && pattern_mode
      |=> reg_rdata[18] == $past(timer_line_b_drive))
    else $error("line B mirror wrong in pattern mode");
  AST_IRQ_RISE: assert property (|(set_vec & mask_next) |=> irq)
    else $error("enabled event did not raise interrupt");
  AST_IRQ_CLEAR: assert property (rd_status && set_vec == 8'h00 |=> !irq)
    else $error("interrupt kept after status read");

  // ----------------------------------------------------------------
  // checks: register port
  // ----------------------------------------------------------------
  AST_C_READ: assert property (reg_rd && reg_addr == tc_status_pkg::OFS_COMPARE_C
      |=> reg_rdata == {16'h0000, $past(compare_c_value)})
    else $error("compare C read wrong");
  AST_C_HOLD: assert property (!wr_c |=> compare_c_value == $past(compare_c_value))
    else $error("compare C changed without a write");
  AST_MASK_READ: assert property (reg_rd && reg_addr == tc_status_pkg::OFS_IRQ_MASK_VIEW
      |=> reg_rdata == {24'h000000, $past(mask_reg)})
    else $error("mask view read wrong");
  AST_MASK_HOLD: assert property (!wr_set && !wr_clr |=> mask_reg == $past(mask_reg))
    else $error("mask changed without a write");
  AST_SET_KEEP: assert property (wr_set
      |=> (mask_reg & ~$past(reg_wdata[7:0])) == ($past(mask_reg) & ~$past(reg_wdata[7:0])))
    else $error("enable set disturbed a bit written as zero");
  AST_CLR_KEEP: assert property (wr_clr
      |=> (mask_reg | $past(reg_wdata[7:0])) == ($past(mask_reg) | $past(reg_wdata[7:0])))
    else $error("enable clear disturbed a bit written as zero");
  AST_WO_READ: assert property (reg_rd && (reg_addr == tc_status_pkg::OFS_IRQ_ENABLE_SET
      || reg_addr == tc_status_pkg::OFS_IRQ_ENABLE_CLEAR) |=> reg_rdata == 32'h0000_0000)
    else $error("write-only register read back nonzero");

  COV_IRQ_RISE: cover property (!irq ##1 irq);
  COV_OVERRUN: cover property (overrun);
  COV_SET_ON_READ: cover property (rd_status && |set_vec);
  COV_PATTERN_CMP: cover property (pattern_mode && core_ev.compare_a);
  COV_MODE_SWITCH: cover property ($rose(pattern_mode));

endmodule : timer_channel_status_irq

/* test/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic pattern_mode = 1'b0;
  logic clock_enabled = 1'b0;
  tc_status_pkg::core_events_t core_ev = '0;
  logic capture_a_read = 1'b0;
  logic capture_b_read = 1'b0;
  logic timer_line_a_in = 1'b0;
  logic timer_line_b_in = 1'b0;
  logic timer_line_a_drive = 1'b0;
  logic timer_line_b_drive = 1'b0;
  logic [15:0] compare_c_value;
  logic irq;
  int mismatches = 0;
  int total_checks = 0;

  always #5 clk = ~clk;

  timer_channel_status_irq DUT (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pattern_mode(pattern_mode), .clock_enabled(clock_enabled), .core_ev(core_ev),
    .capture_a_read(capture_a_read), .capture_b_read(capture_b_read),
    .timer_line_a_in(timer_line_a_in), .timer_line_b_in(timer_line_b_in),
    .timer_line_a_drive(timer_line_a_drive), .timer_line_b_drive(timer_line_b_drive),
    .compare_c_value(compare_c_value), .irq(irq)
  );

  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // data stand only in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    // taken before this edge updates the port, so it is the word launched by the strobe
    @(posedge clk);
    v = reg_rdata;
  endtask : rd

  task automatic ev(input logic [6:0] e);
    @(posedge clk);
    core_ev <= e;
    @(posedge clk);
    core_ev <= '0;
    // one more edge so flags and irq already show the pulse
    @(posedge clk);
  endtask : ev

  // m[0] reads capture register A, m[1] capture register B
  task automatic cap_rd(input logic [1:0] m);
    @(posedge clk);
    capture_a_read <= m[0];
    capture_b_read <= m[1];
    @(posedge clk);
    capture_a_read <= 1'b0;
    capture_b_read <= 1'b0;
  endtask : cap_rd

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    chk(v, e);
  endtask : rd_chk

  function automatic logic [31:0] st(input logic [7:0] f, input logic c, a, b);
    return {13'h0000, b, a, c, 8'h00, f};
  endfunction : st

  task automatic close_out;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    close_out();
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(tc_status_pkg::OFS_COMPARE_C, 32'h0000_0000);
    rd_chk(tc_status_pkg::OFS_EVENT_FLAGS, 32'h0000_0000);
    rd_chk(tc_status_pkg::OFS_IRQ_MASK_VIEW, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0);
    wr(tc_status_pkg::OFS_COMPARE_C, 32'hffff_abcd);
    rd_chk(tc_status_pkg::OFS_COMPARE_C, 32'h0000_abcd);
    chk({16'h0, compare_c_value}, 32'h0000_abcd);
    // capture mode: pins sampled, drive levels opposite so a mix-up shows
    clock_enabled <= 1'b1;
    timer_line_a_in <= 1'b1;
    timer_line_b_drive <= 1'b1;
    ev(7'h7f);
    rd_chk(tc_status_pkg::OFS_EVENT_FLAGS, st(8'hf1, 1'b1, 1'b1, 1'b0));
    rd_chk(tc_status_pkg::OFS_EVENT_FLAGS, st(8'h00, 1'b1, 1'b1, 1'b0));
    // second load with no read between sets overrun
    ev(7'h10);
    ev(7'h10);
    rd_chk(tc_status_pkg::OFS_EVENT_FLAGS, st(8'h22, 1'b1, 1'b1, 1'b0));
    // a read of each capture register before every load keeps overrun clear
    cap_rd(2'b11);
    ev(7'h30);
    cap_rd(2'b11);
    ev(7'h30);
    rd_chk(tc_status_pkg::OFS_EVENT_FLAGS, st(8'h60, 1'b1, 1'b1, 1'b0));
    // pattern mode: driven levels, load events set no flags
    pattern_mode <= 1'b1;
    clock_enabled <= 1'b0;
    ev(7'h20);
    ev(7'h20);
    ev(7'h7f);
    rd_chk(tc_status_pkg::OFS_EVENT_FLAGS, st(8'h9d, 1'b0, 1'b0, 1'b1));
    // mask set, clear, zero-write no effect
    wr(tc_status_pkg::OFS_IRQ_ENABLE_SET, 32'h0000_00ff);
    rd_chk(tc_status_pkg::OFS_IRQ_MASK_VIEW, 32'h0000_00ff);
    wr(tc_status_pkg::OFS_IRQ_ENABLE_CLEAR, 32'h0000_000f);
    wr(tc_status_pkg::OFS_IRQ_ENABLE_SET, 32'h0000_0000);
    rd_chk(tc_status_pkg::OFS_IRQ_MASK_VIEW, 32'h0000_00f0);
    wr(tc_status_pkg::OFS_IRQ_ENABLE_CLEAR, 32'h0000_0000);
    rd_chk(tc_status_pkg::OFS_IRQ_MASK_VIEW, 32'h0000_00f0);
    // masked source keeps irq low, enabled one raises it
    ev(7'h01);
    chk({31'h0, irq}, 32'h0);
    ev(7'h40);
    chk({31'h0, irq}, 32'h1);
    rd_chk(tc_status_pkg::OFS_EVENT_FLAGS, st(8'h81, 1'b0, 1'b0, 1'b1));
    chk({31'h0, irq}, 32'h0);
    // write-only, unmapped and read-only places
    wr(tc_status_pkg::OFS_IRQ_MASK_VIEW, 32'h0000_000f);
    rd_chk(tc_status_pkg::OFS_IRQ_MASK_VIEW, 32'h0000_00f0);
    rd_chk(tc_status_pkg::OFS_IRQ_ENABLE_SET, 32'h0000_0000);
    rd_chk(8'h00, 32'h0000_0000);
    close_out();
  end
endmodule : tb_top
